// [alert_host.sv]
`timescale 1ns/1ps

module alert_host (
    input  wire logic out_level,
    input  wire logic drive_en,
    output logic      pin
);
    // pull-up holds the line high unless the device pulls it
    assign pin = drive_en ? out_level : 1'b1;
endmodule : alert_host

// [fault_counter.sv]
`timescale 1ns/1ps

module fault_counter #(
    parameter int CNT_W = 3
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             sample,
    input  wire logic             over,
    input  wire logic [CNT_W-1:0] need,
    output logic                  met
);

    logic [CNT_W:0] run;

    initial
    begin
        if (CNT_W < 1 || CNT_W > 8)
        begin
            $error("fault_counter: CNT_W out of range");
        end
    end

    // this conversion completes the required run of over-limit results
    assign met = sample & over & (run >= {1'b0, need});

    // consecutive over-limit conversions, saturating one past the need
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run <= '0;
        end
        else if (sample)
        begin
            if (!over)
            begin
                run <= '0;
            end
            else if (run <= {1'b0, need})
            begin
                run <= run + 1'b1;
            end
        end
    end

endmodule : fault_counter

// [overtemp_alert.sv]
// How it works
// - overtemperature and smbus alert modes, comparator/interrupt
// - power up selects overtemperature mode
// - power up selects comparator behaviour
// - comparator asserts when temperature reaches trip limit
// - comparator releases only below hysteresis limit
// - shutdown holds the comparator result
// - interrupt asserts after consecutive over-limit conversions
// - any completed register read clears latched alert; a fault run in the same cycle wins
// - cleared alert waits for a new over-limit conversion
// - trip limit compared as signed two's complement
// - trip limit resets to plus eighty degrees
`timescale 1ns/1ps

module overtemp_alert #(
    parameter int TEMP_W  = 16,
    parameter int FAULT_W = 3
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        conv_valid,
    input  wire logic [15:0] conv_temp,
    output logic             shutdown_out,
    input  wire logic        alert_pin_in,
    output logic             overtemp_alert_out,
    output logic             overtemp_alert_oe,
    output logic             irq
);

    overtemp_pkg::ctrl_s        ctrl;
    logic [15:0]                trip_limit;
    logic [15:0]                hysteresis_limit;
    logic [15:0]                last_temp;
    logic [overtemp_pkg::irq_w-1:0] irq_status;
    logic [overtemp_pkg::irq_w-1:0] irq_mask;
    logic [overtemp_pkg::irq_w-1:0] next_irq_status;
    logic [overtemp_pkg::irq_w-1:0] irq_event;
    logic                       comp_alert;
    logic                       latch_alert;
    logic                       alert_q;
    logic                       alert;
    logic                       latched_mode;
    logic                       sample;
    logic                       over_trip;
    logic                       under_hyst;
    logic                       fault_met;
    logic                       setup;
    logic                       access;
    logic                       wr;
    logic                       rd_done;
    logic                       mapped;
    logic [31:0]                next_prdata;
    logic [31:0]                irq_wdata;

    initial
    begin
        if (TEMP_W != 16)
        begin
            $error("overtemp_alert: TEMP_W must be 16");
        end
        if (FAULT_W != 3)
        begin
            $error("overtemp_alert: FAULT_W must match the control field");
        end
    end

    // apb phase decode; the slave answers in the first access cycle
    assign setup   = psel & ~penable;
    assign access  = psel & penable & pready;
    assign wr      = access & pwrite;
    assign rd_done = access & ~pwrite;

    // address decode of the mapped words
    always_comb
    begin
        case (paddr)
            overtemp_pkg::ctrl_addr,
            overtemp_pkg::trip_limit_addr,
            overtemp_pkg::hyst_limit_addr,
            overtemp_pkg::temp_addr,
            overtemp_pkg::state_addr,
            overtemp_pkg::irq_status_addr,
            overtemp_pkg::irq_mask_addr: mapped = 1'b1;
            default:                     mapped = 1'b0;
        endcase
    end

    // read data mux, unmapped words and reserved bits read zero
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            overtemp_pkg::ctrl_addr:
                next_prdata[6:0] = ctrl[6:0];
            overtemp_pkg::trip_limit_addr:
                next_prdata[15:0] = trip_limit;
            overtemp_pkg::hyst_limit_addr:
                next_prdata[15:0] = hysteresis_limit;
            overtemp_pkg::temp_addr:
                next_prdata[15:0] = last_temp;
            overtemp_pkg::state_addr:
                next_prdata[3:0] = {alert_pin_in, latch_alert, comp_alert, alert};
            overtemp_pkg::irq_status_addr:
                next_prdata[overtemp_pkg::irq_w-1:0] = irq_status;
            overtemp_pkg::irq_mask_addr:
                next_prdata[overtemp_pkg::irq_w-1:0] = irq_mask;
            default:
                next_prdata = 32'h0000_0000;
        endcase
    end

    // pready rises for the access cycle that follows each setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= setup;
        end
    end

    // read data and error are captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= ~mapped;
        end
        else if (access)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // control register: mode, polarity, shutdown, fault run length
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= overtemp_pkg::ctrl_reset;
        end
        else if (wr && paddr == overtemp_pkg::ctrl_addr && pstrb[0])
        begin
            ctrl          <= overtemp_pkg::ctrl_s'(pwdata[7:0]);
            ctrl.reserved <= 1'b0;
        end
    end

    // limit registers, written per byte lane
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trip_limit       <= overtemp_pkg::trip_limit_reset;
            hysteresis_limit <= overtemp_pkg::hyst_limit_reset;
        end
        else if (wr)
        begin
            if (paddr == overtemp_pkg::trip_limit_addr)
            begin
                if (pstrb[0])
                begin
                    trip_limit[7:0] <= pwdata[7:0];
                end
                if (pstrb[1])
                begin
                    trip_limit[15:8] <= pwdata[15:8];
                end
            end
            if (paddr == overtemp_pkg::hyst_limit_addr)
            begin
                if (pstrb[0])
                begin
                    hysteresis_limit[7:0] <= pwdata[7:0];
                end
                if (pstrb[1])
                begin
                    hysteresis_limit[15:8] <= pwdata[15:8];
                end
            end
        end
    end

    // conversions are ignored while shut down, so every result is held
    assign sample       = conv_valid & ~ctrl.shutdown;
    assign over_trip    = $signed(conv_temp) >= $signed(trip_limit);
    assign under_hyst   = $signed(conv_temp) < $signed(hysteresis_limit);
    assign latched_mode = ctrl.interrupt_mode | ctrl.smbus_alert;

    // latest conversion result
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_temp <= overtemp_pkg::temp_reset;
        end
        else if (sample)
        begin
            last_temp <= conv_temp;
        end
    end

    // comparator state with hysteresis, holding between the limits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            comp_alert <= 1'b0;
        end
        else if (sample)
        begin
            if (over_trip)
            begin
                comp_alert <= 1'b1;
            end
            else if (under_hyst)
            begin
                comp_alert <= 1'b0;
            end
        end
    end

    // consecutive fault run for the latched behaviour
    fault_counter #(
        .CNT_W   (FAULT_W)
    ) u_fault_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .sample  (sample),
        .over    (over_trip),
        .need    (ctrl.fault_need),
        .met     (fault_met)
    );

    // latched alert: set by a fault run, cleared by any completed read; a fault run in the same cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latch_alert <= 1'b0;
        end
        else if (!latched_mode)
        begin
            latch_alert <= 1'b0;
        end
        else if (fault_met)
        begin
            latch_alert <= 1'b1;
        end
        else if (rd_done)
        begin
            latch_alert <= 1'b0;
        end
    end

    // internal alert state, independent of polarity
    assign alert = latched_mode ? latch_alert : comp_alert;

    // open-drain pin: drive low while active, polarity inverts the sense
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overtemp_alert_out <= 1'b0;
            overtemp_alert_oe  <= 1'b0;
            shutdown_out       <= 1'b0;
            alert_q            <= 1'b0;
        end
        else
        begin
            overtemp_alert_out <= 1'b0;
            overtemp_alert_oe  <= alert ^ ctrl.polarity;
            shutdown_out       <= ctrl.shutdown;
            alert_q            <= alert;
        end
    end

    // interrupt events: alert rose, alert fell, conversion taken
    assign irq_event = {sample, alert_q & ~alert, alert & ~alert_q};

    assign irq_wdata = (wr && paddr == overtemp_pkg::irq_status_addr && pstrb[0])
                     ? pwdata : 32'h0000_0000;

    // sticky status, write one to clear, a new event wins over the clear
    always_comb
    begin
        next_irq_status = (irq_status & ~irq_wdata[overtemp_pkg::irq_w-1:0]) | irq_event;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status <= overtemp_pkg::irq_reset;
        end
        else
        begin
            irq_status <= next_irq_status;
        end
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_mask <= overtemp_pkg::irq_reset;
        end
        else if (wr && paddr == overtemp_pkg::irq_mask_addr && pstrb[0])
        begin
            irq_mask <= pwdata[overtemp_pkg::irq_w-1:0];
        end
    end

    // level interrupt while an unmasked status bit is set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(next_irq_status & irq_mask);
        end
    end

endmodule : overtemp_alert

// [overtemp_alert_chk.sv]
`timescale 1ns/1ps

module overtemp_alert_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        conv_valid,
    input wire logic        shutdown_out,
    input wire logic        overtemp_alert_out,
    input wire logic        overtemp_alert_oe
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // bus answers one cycle after setup and only for one cycle
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    // open drain: the pin is only ever pulled low
    a_out_low: assert property (overtemp_alert_out == 1'b0)
        else $error("pin driven high");
    // pin drive moves two edges after a conversion or a bus access
    a_oe_rise_cause: assert property ($rose(overtemp_alert_oe) |->
        $past(conv_valid, 2) || $past(psel && penable && pwrite, 2))
        else $error("drive rose without cause");
    a_oe_fall_cause: assert property ($fell(overtemp_alert_oe) |->
        $past(conv_valid, 2) || $past(psel && penable, 2))
        else $error("drive fell without cause");
    // results are ignored while shut down, so the pin holds
    a_shutdown_hold: assert property ($past(shutdown_out, 2) &&
        $past(shutdown_out, 1) && !$past(psel, 2) && !$past(psel, 3)
        |-> $stable(overtemp_alert_oe))
        else $error("pin changed in shutdown");
endmodule : overtemp_alert_chk

bind overtemp_alert overtemp_alert_chk chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid),
    .shutdown_out(shutdown_out), .overtemp_alert_out(overtemp_alert_out),
    .overtemp_alert_oe(overtemp_alert_oe)
);

// [overtemp_pkg.sv]
package overtemp_pkg;

    // register byte offsets
    localparam logic [7:0]  ctrl_addr         = 8'h00;
    localparam logic [7:0]  trip_limit_addr   = 8'h04;
    localparam logic [7:0]  hyst_limit_addr   = 8'h08;
    localparam logic [7:0]  temp_addr         = 8'h0c;
    localparam logic [7:0]  state_addr        = 8'h10;
    localparam logic [7:0]  irq_status_addr   = 8'h14;
    localparam logic [7:0]  irq_mask_addr     = 8'h18;

    // values after reset
    localparam logic [15:0] trip_limit_reset  = 16'h5000;
    localparam logic [15:0] hyst_limit_reset  = 16'h4b00;
    localparam logic [15:0] temp_reset        = 16'h0000;
    localparam logic [2:0]  irq_reset         = 3'h0;

    // interrupt status and mask bit positions
    localparam int          irq_alert_set_bit = 0;
    localparam int          irq_alert_clr_bit = 1;
    localparam int          irq_conv_bit      = 2;
    localparam int          irq_w             = 3;

    // control register layout, low byte of the word
    typedef struct packed {
        logic       reserved;
        logic [2:0] fault_need;
        logic       smbus_alert;
        logic       polarity;
        logic       interrupt_mode;
        logic       shutdown;
    } ctrl_s;

    localparam ctrl_s       ctrl_reset        = '{default: 1'b0};

endpackage : overtemp_pkg

// [testbench.sv]
`timescale 1ns/1ps

module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        conv_valid = 1'b0;
    logic [15:0] conv_temp = 16'h0;
    logic        shutdown_out;
    logic        pin;
    logic        out;
    logic        oe;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    logic [15:0] t;
    logic        s;
    int          seed;
    int          n_mismatch = 0;
    int          n_compared = 0;

    always #20 pclk = ~pclk;

    overtemp_alert dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_valid(conv_valid), .conv_temp(conv_temp),
        .shutdown_out(shutdown_out), .alert_pin_in(pin), .overtemp_alert_out(out),
        .overtemp_alert_oe(oe), .irq(irq)
    );

    alert_host host (.out_level(out), .drive_en(oe), .pin(pin));

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one bus transfer: setup, then access until ready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge pclk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
            chk(32'h0, 32'h1);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(rdat, e);
    endtask : rd

    // one conversion pulse, data lines scrambled afterwards
    task automatic conv(input logic [15:0] v);
        @(posedge pclk);
        conv_valid <= 1'b1;
        conv_temp <= v;
        @(posedge pclk);
        conv_valid <= 1'b0;
        conv_temp <= ~v;
    endtask : conv

    task automatic pin_is(input logic lvl);
        repeat (3) @(posedge pclk);
        chk({31'h0, pin}, {31'h0, lvl});
    endtask : pin_is

    // comparator state for trip -2 and hysteresis -4 degrees
    function automatic logic cmp_next(input logic st, input logic [15:0] v);
        if ($signed(v) >= $signed(16'hfe00))
            return 1'b1;
        if ($signed(v) < $signed(16'hfc00))
            return 1'b0;
        return st;
    endfunction : cmp_next

    // main sequence
    initial
    begin
        seed = 32'h7e59;
        s = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(overtemp_pkg::trip_limit_addr, 32'h5000);
        rd(overtemp_pkg::hyst_limit_addr, 32'h4b00);
        rd(overtemp_pkg::ctrl_addr, 32'h0);
        chk({31'h0, pin}, 32'h1);
        $display("done reset values");
        conv(16'h5000);
        pin_is(1'b0);
        conv(16'h4b00);
        pin_is(1'b0);
        apb(overtemp_pkg::ctrl_addr, 1'b1, 32'h1);
        conv(16'h8000);
        pin_is(1'b0);
        chk({31'h0, shutdown_out}, 32'h1);
        apb(overtemp_pkg::ctrl_addr, 1'b1, 32'h0);
        conv(16'h4aff);
        pin_is(1'b1);
        $display("done comparator");
        apb(overtemp_pkg::trip_limit_addr, 1'b1, 32'hfe00);
        apb(overtemp_pkg::hyst_limit_addr, 1'b1, 32'hfc00);
        rd(overtemp_pkg::hyst_limit_addr, 32'hfc00);
        for (int i = 0; i < 24; i++)
        begin
            t = (i == 0) ? 16'h7fff : (i == 1) ? 16'h8000 : 16'hfb00 + 16'($random(seed) & 32'h7ff);
            s = cmp_next(s, t);
            conv(t);
            pin_is(~s);
        end
        conv(16'h8000);
        apb(overtemp_pkg::ctrl_addr, 1'b1, 32'h4);
        pin_is(1'b0);
        conv(16'h7fff);
        pin_is(1'b1);
        conv(16'h8000);
        $display("done signed and polarity");
        apb(overtemp_pkg::trip_limit_addr, 1'b1, 32'h1000);
        apb(overtemp_pkg::irq_mask_addr, 1'b1, 32'h1);
        apb(overtemp_pkg::ctrl_addr, 1'b1, 32'h22);
        apb(overtemp_pkg::irq_status_addr, 1'b1, 32'h7);
        conv(16'h1000);
        conv(16'h7000);
        conv(16'h0fff);
        conv(16'h1000);
        conv(16'h1000);
        pin_is(1'b1);
        conv(16'h1000);
        pin_is(1'b0);
        chk({31'h0, irq}, 32'h1);
        apb(overtemp_pkg::irq_status_addr, 1'b1, 32'h1);
        pin_is(1'b0);
        chk({31'h0, irq}, 32'h0);
        rd(overtemp_pkg::temp_addr, 32'h1000);
        pin_is(1'b1);
        pin_is(1'b1);
        conv(16'h1000);
        pin_is(1'b0);
        apb(overtemp_pkg::irq_mask_addr, 1'b1, 32'h0);
        pin_is(1'b0);
        chk({31'h0, irq}, 32'h0);
        rd(overtemp_pkg::irq_status_addr, 32'h7);
        $display("done interrupt mode");
        for (int k = 0; k < 2; k++)
        begin
            apb(overtemp_pkg::ctrl_addr, 1'b1, k ? 32'h8 : 32'h2);
            conv(16'h1000);
            pin_is(1'b0);
            rd(8'hfc, 32'h0);
            chk({31'h0, rerr}, 32'h1);
            pin_is(1'b1);
        end
        rd(overtemp_pkg::state_addr, 32'h0000_000a);
        $display("done latched modes");
        report_and_stop();
    end

    // watchdog against a hung handshake
    initial
    begin
        #400000;
        n_mismatch++;
        report_and_stop();
    end
endmodule : testbench
